// ### shl_limiter.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`include "shl_consts.svh"
module shl_limiter #(
    parameter int HOLD_SAMPLES = `SHL_HOLD_SAMPLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [`SHL_ADDR_W-1:0] reg_addr,
    input wire logic [`SHL_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`SHL_DATA_W-1:0] reg_rdata,
    input wire logic amp_on_high_rail,
    input wire logic [15:0] high_rail_mv,
    input wire logic [15:0] batt_rail_mv,
    input wire logic meas_valid,
    input wire shl_pkg::shl_smp_t smp_in,
    output shl_pkg::shl_smp_t smp_out,
    output logic [2:0] amp_gain_code,
    output logic attenuating,
    output logic attenuation_begin_event,
    output logic attenuation_end_event
);
    import shl_pkg::*;

    function automatic logic [24:0] abs25(input logic signed [23:0] x);
        logic [24:0] ext;
        ext = {x[23], x};
        abs25 = x[23] ? 25'(-ext) : ext;
    endfunction

    // one dB per code
    // no-load peak in mV for 4..16dB over the 3.68dBV baseline
    function automatic logic [15:0] max_peak_mv(input logic [3:0] code);
        case (code)
            4'h0: max_peak_mv = 16'h0975;
            4'h1: max_peak_mv = 16'h0A9C;
            4'h2: max_peak_mv = 16'h0BE8;
            4'h3: max_peak_mv = 16'h0D5C;
            4'h4: max_peak_mv = 16'h0EFD;
            4'h5: max_peak_mv = 16'h10D1;
            4'h6: max_peak_mv = 16'h12DF;
            4'h7: max_peak_mv = 16'h152C;
            4'h8: max_peak_mv = 16'h17C1;
            4'h9: max_peak_mv = 16'h1AA7;
            4'hA: max_peak_mv = 16'h1DE8;
            4'hB: max_peak_mv = 16'h218E;
            default: max_peak_mv = 16'h25A6;
        endcase
    endfunction

    // fixed level thresholds 0..-15dBFS as Q15 ratio
    function automatic logic [15:0] level_ratio(input logic [3:0] code);
        case (code)
            4'h0: level_ratio = 16'h8000;
            4'h1: level_ratio = 16'h7215;
            4'h2: level_ratio = 16'h65AD;
            4'h3: level_ratio = 16'h5A9E;
            4'h4: level_ratio = 16'h50C3;
            4'h5: level_ratio = 16'h47FB;
            4'h6: level_ratio = 16'h4027;
            4'h7: level_ratio = 16'h392D;
            4'h8: level_ratio = 16'h32F5;
            4'h9: level_ratio = 16'h2D6B;
            4'hA: level_ratio = 16'h287A;
            4'hB: level_ratio = 16'h2413;
            4'hC: level_ratio = 16'h2027;
            4'hD: level_ratio = 16'h1CA8;
            4'hE: level_ratio = 16'h198A;
            default: level_ratio = 16'h16C3;
        endcase
    endfunction

    function automatic logic [4:0] sat_headroom(input logic signed [4:0] v);
        if (v > `SHL_HR_POS_LIM) begin
            sat_headroom = `SHL_HR_POS_LIM;
        end else if (v < `SHL_HR_NEG_LIM) begin
            sat_headroom = `SHL_HR_NEG_LIM;
        end else begin
            sat_headroom = v;
        end
    endfunction

    logic tracking_enable;
    logic limiter_type_sel;
    logic [3:0] full_scale_gain_sel;
    logic signed [4:0] headroom_setting_field;
    logic [3:0] compressor_rotation_point;
    logic [3:0] level_threshold_sel;
    logic flag_begin;
    logic flag_end;
    logic [2:0] rail_sync;
    logic rail_high;
    logic [15:0] high_mv_q;
    logic [15:0] batt_mv_q;
    logic supply_seen;
    logic [15:0] track_ratio;
    logic [15:0] hold_cnt;
    logic active;
    shl_smp_t lim_smp;

    // register decode
    wire logic wr_ctrl = reg_wr && reg_addr == `SHL_REG_CTRL;
    wire logic wr_gain = reg_wr && reg_addr == `SHL_REG_GAIN;
    wire logic wr_headroom = reg_wr && reg_addr == `SHL_REG_HEADROOM;
    wire logic wr_rotation = reg_wr && reg_addr == `SHL_REG_ROTATION;
    wire logic wr_lvl = reg_wr && reg_addr == `SHL_REG_LVL_THR;
    wire logic wr_status = reg_wr && reg_addr == `SHL_REG_STATUS;
    wire logic clr_begin = wr_status && reg_wdata[`SHL_STAT_BGN_BIT];
    wire logic clr_end = wr_status && reg_wdata[`SHL_STAT_END_BIT];
    wire logic [3:0] gain_wr_val = (reg_wdata[3:0] > `SHL_GAIN_MAX_CODE) ? `SHL_GAIN_MAX_CODE : reg_wdata[3:0];

    // pick the rail that powers the amplifier
    wire logic [15:0] measured_supply = rail_high ? high_mv_q : batt_mv_q;

    // cap gain at 16dB for the max peak
    wire logic [3:0] capped_gain = (full_scale_gain_sel > `SHL_GAIN_CAP_CODE) ? `SHL_GAIN_CAP_CODE :
        full_scale_gain_sel;
    wire logic [15:0] max_peak_output = max_peak_mv(capped_gain);

    // headroom in 2.5% steps, factor is (40 - steps) / 40
    wire logic [5:0] headroom_factor = `SHL_HR_STEPS - {headroom_setting_field[4], headroom_setting_field};

    // target peak numerator against scaled max peak
    wire logic [21:0] target_peak_output = 22'(measured_supply) * 22'(headroom_factor);
    wire logic [21:0] max_peak_scaled = 22'(max_peak_output) * 22'(`SHL_HR_STEPS);

    logic div_busy;
    logic div_done;
    logic [15:0] div_quo;

    // divider restarts as soon as it is free
    shl_divider #(
        .NUM_W(22)
    ) u_ratio (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(!div_busy),
        .num(target_peak_output),
        .den(max_peak_scaled),
        .busy(div_busy),
        .done(div_done),
        .quo(div_quo)
    );

    // supply tracking threshold, unity until a supply is known
    wire logic [15:0] target_attenuation = supply_seen ? track_ratio : `SHL_Q15_UNITY;
    // level limiter uses the fixed threshold
    wire logic [15:0] thr_ratio = !tracking_enable ? `SHL_Q15_UNITY :
        limiter_type_sel ? level_ratio(level_threshold_sel) : target_attenuation;
    wire shl_mode_t mode = !tracking_enable ? SHL_MODE_OFF :
        !limiter_type_sel ? SHL_MODE_DISTORTION :
        (compressor_rotation_point == 4'h0) ? SHL_MODE_LEVEL :
        (level_threshold_sel == 4'h0) ? SHL_MODE_COMPRESSOR : SHL_MODE_COMPRESSOR_LEVEL;

    wire logic [24:0] limit_mag = {1'b0, thr_ratio, 8'h00};
    wire logic [24:0] in_mag = abs25(smp_in.data);
    wire logic over = in_mag > limit_mag;
    wire logic [23:0] limit_pos = limit_mag[23:0];
    // cut only, never boost
    // threshold never exceeds unity, so passing samples keep their level
    wire logic signed [23:0] limited_data = !over ? smp_in.data :
        smp_in.data[23] ? 24'(-limit_pos) : limit_pos;

    // odd codes take 1dB digital trim below the analog step
    wire logic trim_on = full_scale_gain_sel[0];
    wire logic signed [23:0] trimmed_data = trim_on ? lim_smp.data - (lim_smp.data >>> 3) : lim_smp.data;

    wire logic [15:0] next_hold = !tracking_enable ? 16'h0000 :
        (smp_in.valid && over) ? 16'(HOLD_SAMPLES) :
        (smp_in.valid && hold_cnt != 16'h0000) ? hold_cnt - 16'h0001 : hold_cnt;
    wire logic next_active = next_hold != 16'h0000;

    wire logic [`SHL_DATA_W-1:0] status_word = {13'h0000, flag_end, flag_begin, active};
    wire logic [`SHL_DATA_W-1:0] read_val =
        (reg_addr == `SHL_REG_CTRL) ? {14'h0000, limiter_type_sel, tracking_enable} :
        (reg_addr == `SHL_REG_GAIN) ? {12'h000, full_scale_gain_sel} :
        (reg_addr == `SHL_REG_HEADROOM) ? {11'h000, headroom_setting_field} :
        (reg_addr == `SHL_REG_ROTATION) ? {12'h000, compressor_rotation_point} :
        (reg_addr == `SHL_REG_LVL_THR) ? {12'h000, level_threshold_sel} :
        (reg_addr == `SHL_REG_STATUS) ? status_word :
        (reg_addr == `SHL_REG_THRESH) ? thr_ratio :
        (reg_addr == `SHL_REG_SUPPLY) ? measured_supply :
        (reg_addr == `SHL_REG_MODE) ? {13'h0000, mode} : 16'h0000;

    assign attenuating = active;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tracking_enable <= 1'b0;
            limiter_type_sel <= 1'b0;
            full_scale_gain_sel <= `SHL_GAIN_RST;
            headroom_setting_field <= `SHL_HR_RST;
            compressor_rotation_point <= 4'h0;
            level_threshold_sel <= 4'h0;
            reg_rdata <= '0;
        end else begin
            if (wr_ctrl) begin
                tracking_enable <= reg_wdata[`SHL_CTRL_EN_BIT];
                limiter_type_sel <= reg_wdata[`SHL_CTRL_TYPE_BIT];
            end
            // gain codes 4..18dB, larger codes held at 18dB
            if (wr_gain) begin
                full_scale_gain_sel <= gain_wr_val;
            end
            if (wr_headroom) begin
                headroom_setting_field <= sat_headroom(reg_wdata[4:0]);
            end
            if (wr_rotation) begin
                compressor_rotation_point <= reg_wdata[3:0];
            end
            if (wr_lvl) begin
                level_threshold_sel <= reg_wdata[3:0];
            end
            reg_rdata <= reg_rd ? read_val : '0;
        end
    end

    // rail pin: three stages, change taken when last two agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rail_sync <= 3'h0;
            rail_high <= 1'b0;
        end else begin
            rail_sync <= {rail_sync[1:0], amp_on_high_rail};
            if (rail_sync[2] == rail_sync[1]) begin
                rail_high <= rail_sync[2];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_mv_q <= 16'h0000;
            batt_mv_q <= 16'h0000;
            supply_seen <= 1'b0;
            track_ratio <= `SHL_Q15_UNITY;
        end else begin
            if (meas_valid) begin
                high_mv_q <= high_rail_mv;
                batt_mv_q <= batt_rail_mv;
                supply_seen <= 1'b1;
            end
            if (div_done) begin
                track_ratio <= div_quo;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lim_smp <= '0;
            smp_out <= '0;
        end else begin
            lim_smp.valid <= smp_in.valid;
            lim_smp.data <= limited_data;
            smp_out.valid <= lim_smp.valid;
            smp_out.data <= trimmed_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            amp_gain_code <= 3'h0;
        end else begin
            amp_gain_code <= 3'((5'(full_scale_gain_sel) + 5'h01) >> 1);
        end
    end

    // activity with hold, begin and end pulses, sticky flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt <= 16'h0000;
            active <= 1'b0;
            attenuation_begin_event <= 1'b0;
            attenuation_end_event <= 1'b0;
            flag_begin <= 1'b0;
            flag_end <= 1'b0;
        end else begin
            hold_cnt <= next_hold;
            active <= next_active;
            attenuation_begin_event <= next_active && !active;
            attenuation_end_event <= !next_active && active;
            flag_begin <= (next_active && !active) || (flag_begin && !clr_begin);
            flag_end <= (!next_active && active) || (flag_end && !clr_end);
        end
    end

    wire logic [24:0] lim_out_mag = abs25(lim_smp.data);

    sequence seq_limit_start;
        tracking_enable && smp_in.valid && over && !active;
    endsequence

    sequence seq_activity_ends;
        active ##1 !active;
    endsequence

    chk_pass_below: assert property (@(posedge mclk) disable iff (!rst_n)
        (smp_in.valid && !over) |=> (lim_smp.valid && lim_smp.data == $past(smp_in.data)))
        else $error("sample below threshold was altered");
    chk_clamp_above: assert property (@(posedge mclk) disable iff (!rst_n)
        (smp_in.valid && over) |=> (lim_out_mag == $past(limit_mag)))
        else $error("sample above threshold not cut to threshold");
    chk_never_gain: assert property (@(posedge mclk) disable iff (!rst_n)
        lim_smp.valid |-> (lim_out_mag <= abs25($past(smp_in.data))))
        else $error("limiter raised a sample level");
    chk_off_unity: assert property (@(posedge mclk) disable iff (!rst_n)
        !tracking_enable |-> (thr_ratio == `SHL_Q15_UNITY && !over))
        else $error("threshold below unity while disabled");
    chk_gain_cap: assert property (@(posedge mclk) disable iff (!rst_n)
        (full_scale_gain_sel >= `SHL_GAIN_CAP_CODE) |-> (max_peak_output == max_peak_mv(`SHL_GAIN_CAP_CODE)))
        else $error("max peak not capped at 16dB");
    chk_rail_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        rail_high |-> (measured_supply == high_mv_q))
        else $error("supply not taken from high rail");
    chk_track_update: assert property (@(posedge mclk) disable iff (!rst_n)
        div_done |=> (track_ratio == $past(div_quo)))
        else $error("threshold not refreshed from new ratio");
    chk_level_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        (tracking_enable && limiter_type_sel) |-> (thr_ratio == level_ratio(level_threshold_sel)))
        else $error("level limiter not using fixed threshold");
    chk_begin_event: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_limit_start |=> (attenuation_begin_event && active))
        else $error("begin event missing");
    chk_end_event: assert property (@(posedge mclk) disable iff (!rst_n)
        seq_activity_ends |-> attenuation_end_event)
        else $error("end event missing");
    chk_headroom_range: assert property (@(posedge mclk) disable iff (!rst_n)
        (headroom_setting_field <= `SHL_HR_POS_LIM) && (headroom_setting_field >= `SHL_HR_NEG_LIM))
        else $error("headroom outside +-20 percent");
endmodule

// ### shl_consts.svh
`ifndef SHL_CONSTS_SVH
`define SHL_CONSTS_SVH

`define SHL_ADDR_W 4
`define SHL_DATA_W 16
`define SHL_REG_CTRL 4'h0
`define SHL_REG_GAIN 4'h1
`define SHL_REG_HEADROOM 4'h2
`define SHL_REG_ROTATION 4'h3
`define SHL_REG_LVL_THR 4'h4
`define SHL_REG_STATUS 4'h5
`define SHL_REG_THRESH 4'h6
`define SHL_REG_SUPPLY 4'h7
`define SHL_REG_MODE 4'h8
`define SHL_CTRL_EN_BIT 0
`define SHL_CTRL_TYPE_BIT 1
`define SHL_STAT_ACTIVE_BIT 0
`define SHL_STAT_BGN_BIT 1
`define SHL_STAT_END_BIT 2
`define SHL_GAIN_RST 4'h0
`define SHL_GAIN_MAX_CODE 4'hE
`define SHL_GAIN_CAP_CODE 4'hC
`define SHL_HR_RST 5'h00
`define SHL_HR_POS_LIM 5'sh08
`define SHL_HR_NEG_LIM 5'sh18
`define SHL_HR_STEPS 6'h28
`define SHL_Q15_UNITY 16'h8000
`define SHL_DIV_LAST 4'hE
`define SHL_HOLD_SAMPLES 32'h0000_0400
`endif

// ### shl_pkg.sv
package shl_pkg;
    typedef struct packed {
        logic valid;
        logic signed [23:0] data;
    } shl_smp_t;

    typedef enum logic [1:0] {
        SHL_DIV_IDLE = 2'h0,
        SHL_DIV_RUN = 2'h1,
        SHL_DIV_DONE = 2'h3
    } shl_div_state_t;

    typedef enum logic [2:0] {
        SHL_MODE_OFF = 3'h0,
        SHL_MODE_DISTORTION = 3'h1,
        SHL_MODE_LEVEL = 3'h2,
        SHL_MODE_COMPRESSOR = 3'h3,
        SHL_MODE_COMPRESSOR_LEVEL = 3'h4
    } shl_mode_t;
endpackage

// ### shl_divider.sv
`include "shl_consts.svh"
module shl_divider #(
    parameter int NUM_W = 22
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [NUM_W-1:0] num,
    input wire logic [NUM_W-1:0] den,
    output logic busy,
    output logic done,
    output logic [15:0] quo
);
    import shl_pkg::*;

    shl_div_state_t state;
    logic [NUM_W:0] rem;
    logic [NUM_W-1:0] den_q;
    logic [3:0] steps;
    logic [14:0] bits;

    wire logic [NUM_W:0] rem_shift = {rem[NUM_W-1:0], 1'b0};
    wire logic fits = rem_shift >= {1'b0, den_q};
    wire logic [NUM_W:0] rem_sub = rem_shift - {1'b0, den_q};
    // ratio at or above one means no attenuation
    wire logic saturate = num >= den;

    assign busy = state != SHL_DIV_IDLE;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SHL_DIV_IDLE;
            rem <= '0;
            den_q <= '0;
            steps <= '0;
            bits <= '0;
            done <= 1'b0;
            quo <= `SHL_Q15_UNITY;
        end else begin
            done <= 1'b0;
            case (state)
                SHL_DIV_IDLE: begin
                    if (start && saturate) begin
                        quo <= `SHL_Q15_UNITY;
                        done <= 1'b1;
                    end else if (start) begin
                        rem <= {1'b0, num};
                        den_q <= den;
                        steps <= '0;
                        state <= SHL_DIV_RUN;
                    end
                end
                SHL_DIV_RUN: begin
                    rem <= fits ? rem_sub : rem_shift;
                    bits <= {bits[13:0], fits};
                    steps <= steps + 4'h1;
                    if (steps == `SHL_DIV_LAST) begin
                        state <= SHL_DIV_DONE;
                    end
                end
                SHL_DIV_DONE: begin
                    quo <= {1'b0, bits};
                    done <= 1'b1;
                    state <= SHL_DIV_IDLE;
                end
                default: begin
                    state <= SHL_DIV_IDLE;
                end
            endcase
        end
    end

    chk_div_latency: assert property (@(posedge mclk) disable iff (!rst_n)
        (start && !busy && !saturate) |-> ##17 (done && quo < `SHL_Q15_UNITY))
        else $error("ratio not ready 17 cycles after start");
    chk_div_clamp: assert property (@(posedge mclk) disable iff (!rst_n)
        (start && !busy && saturate) |=> (done && quo == `SHL_Q15_UNITY))
        else $error("ratio above one not clamped to unity");
endmodule

// ### shl_source_model.sv
module shl_source_model (
    input wire logic mclk,
    output shl_pkg::shl_smp_t smp_in,
    output logic amp_on_high_rail,
    output logic [15:0] high_rail_mv,
    output logic [15:0] batt_rail_mv,
    output logic meas_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import shl_pkg::*;

    initial begin
        smp_in = '0;
        amp_on_high_rail = 1'b1;
        high_rail_mv = 16'h0000;
        batt_rail_mv = 16'h0000;
        meas_valid = 1'b0;
    end

    task measure(input logic hi, input logic [15:0] h, input logic [15:0] b);
        @(posedge mclk);
        amp_on_high_rail <= hi;
        high_rail_mv <= h;
        batt_rail_mv <= b;
        meas_valid <= 1'b1;
        @(posedge mclk);
        meas_valid <= 1'b0;
        high_rail_mv <= ~h;
        batt_rail_mv <= ~b;
    endtask

    // one word, then garbage data off-valid
    task send(input logic signed [23:0] x, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        smp_in <= '{valid: 1'b1, data: x};
        @(posedge mclk);
        smp_in <= '{valid: 1'b0, data: ~x};
    endtask
endmodule

// ### testbench.sv
`include "shl_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import shl_pkg::*;
    logic mclk, rst_n, reg_wr, reg_rd, amp_on_high_rail, meas_valid, attenuating, bgn, fin;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, high_rail_mv, batt_rail_mv, rv;
    logic [2:0] amp_gain_code;
    shl_smp_t smp_in, smp_out;
    int n_errors, total_checks, n_bgn, n_end, gsel, thr, e;
    int exp_q[$];
    int tol_q[$];
    int cg[6] = '{0, 12, 14, 13, 5, 0};
    int ch[6] = '{0, 8, 8, -8, -4, -8};

    shl_limiter #(.HOLD_SAMPLES(4)) u_shl_limiter (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .amp_on_high_rail(amp_on_high_rail), .high_rail_mv(high_rail_mv), .batt_rail_mv(batt_rail_mv),
        .meas_valid(meas_valid), .smp_in(smp_in), .smp_out(smp_out), .amp_gain_code(amp_gain_code),
        .attenuating(attenuating), .attenuation_begin_event(bgn), .attenuation_end_event(fin));
    shl_source_model u_shl_source_model (.mclk(mclk), .smp_in(smp_in), .amp_on_high_rail(amp_on_high_rail),
        .high_rail_mv(high_rail_mv), .batt_rail_mv(batt_rail_mv), .meas_valid(meas_valid));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    function automatic int model_ratio(int s, int g, int h);
        longint mp;
        longint r;
        mp = longint'(1000.0 * 10.0 ** ((3.68 + 4.0 + real'(g > 12 ? 12 : g)) / 20.0));
        r = longint'(s) * (40 - h) * 32768 / (40 * mp);
        return r >= 32768 ? 32768 : int'(r);
    endfunction

    task automatic chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            n_errors++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task complete_run;
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    // expected word from the hard cut and odd-code trim
    task push(input int x, input int t, input int gap);
        int y, tol;
        y = x;
        tol = 0;
        if (x > t || x < -t) begin
            y = x > 0 ? t : -t;
            tol = 512;
        end
        if (gsel % 2 == 1) y = y - (y >>> 3);
        exp_q.push_back(y);
        tol_q.push_back(tol);
        u_shl_source_model.send(24'(x), gap);
    endtask

    always @(posedge mclk) begin
        int d;
        if (bgn === 1'b1) n_bgn++;
        if (fin === 1'b1) n_end++;
        if (smp_out.valid === 1'b1) begin
            if (exp_q.size() == 0) chk(1'b0, "unexpected sample");
            else begin
                d = int'(smp_out.data) - exp_q.pop_front();
                chk(d <= tol_q[0] && d >= -tol_q[0], "sample mismatch");
                void'(tol_q.pop_front());
            end
        end
    end

    initial begin
        repeat (50000) @(posedge mclk);
        chk(1'b0, "timeout");
        complete_run;
    end

    initial begin
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        gsel = 0;
        void'($urandom(36646));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`SHL_REG_THRESH);
        chk(rv === 16'h8000, "thresh reset");
        rd(4'hF);
        chk(rv === 16'h0000, "unmapped read");
        for (gsel = 0; gsel < 2; gsel++) begin
            wr(`SHL_REG_GAIN, 16'(gsel));
            repeat (8) push(int'($urandom_range(16777214)) - 8388607, 8388608, $urandom_range(2));
        end
        gsel = 0;
        repeat (4) @(posedge mclk);
        chk(amp_gain_code === 3'h1, "analog step");
        wr(`SHL_REG_GAIN, 16'h000F);
        rd(`SHL_REG_GAIN);
        chk(rv === 16'h000E && amp_gain_code === 3'h7, "gain clamp");
        wr(`SHL_REG_HEADROOM, 16'h000C);
        rd(`SHL_REG_HEADROOM);
        chk(rv === 16'h0008, "headroom clamp");
        u_shl_source_model.measure(1'b1, 16'd1210, 16'd3000);
        wr(`SHL_REG_CTRL, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            wr(`SHL_REG_GAIN, 16'(cg[i]));
            wr(`SHL_REG_HEADROOM, 16'(ch[i]) & 16'h001F);
            repeat (60) @(posedge mclk);
            rd(`SHL_REG_THRESH);
            e = int'(rv) - model_ratio(1210, cg[i], ch[i]);
            chk(e <= 1 && e >= -1, "tracked threshold");
        end
        wr(`SHL_REG_GAIN, 16'h0000);
        wr(`SHL_REG_HEADROOM, 16'h0000);
        u_shl_source_model.measure(1'b0, 16'd1000, 16'd3000);
        repeat (60) @(posedge mclk);
        rd(`SHL_REG_SUPPLY);
        chk(rv === 16'd3000, "rail select");
        rd(`SHL_REG_THRESH);
        chk(rv === 16'h8000, "ratio clamp");
        u_shl_source_model.measure(1'b1, 16'd1210, 16'd3000);
        repeat (60) @(posedge mclk);
        thr = model_ratio(1210, 0, 0) * 256;
        push(8000000, thr, 0);
        repeat (4) @(posedge mclk);
        chk(attenuating === 1'b1, "active level");
        repeat (4) push(int'($urandom_range(thr)) - thr / 2, thr, 0);
        repeat (8) @(posedge mclk);
        chk(n_bgn == 1 && n_end == 1 && attenuating === 1'b0, "event pulses");
        rd(`SHL_REG_STATUS);
        chk(rv === 16'h0006, "sticky flags");
        wr(`SHL_REG_STATUS, 16'h0006);
        rd(`SHL_REG_STATUS);
        chk(rv === 16'h0000, "flag clear");
        rd(`SHL_REG_MODE);
        chk(rv === 16'h0001, "mode one");
        repeat (8) push(int'($urandom_range(16777214)) - 8388607, thr, 0);
        repeat (5) push(0, thr, 1);
        wr(`SHL_REG_CTRL, 16'h0003);
        rd(`SHL_REG_MODE);
        chk(rv === 16'h0002, "level limiter mode");
        wr(`SHL_REG_ROTATION, 16'h0003);
        rd(`SHL_REG_MODE);
        chk(rv === 16'h0003, "compressor mode");
        wr(`SHL_REG_LVL_THR, 16'h0006);
        rd(`SHL_REG_MODE);
        chk(rv === 16'h0004, "compressor with limiter mode");
        thr = int'(32768.0 * (10.0 ** (-6.0 / 20.0)));
        rd(`SHL_REG_THRESH);
        chk(int'(rv) == thr, "fixed level threshold");
        repeat (6) push(int'($urandom_range(16777214)) - 8388607, thr * 256, 0);
        repeat (10) @(posedge mclk);
        chk(exp_q.size() == 0, "samples lost");
        complete_run;
    end
endmodule
